// >>> inc/trigger_gate_pkg.sv
// Purpose: shared types and constants of the measurement trigger gate
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes:   configuration travels as one packed struct
package trigger_gate_pkg;

  localparam int CLOCK_PERIOD_NS = 4;
  localparam int DATA_WIDTH      = 32;
  localparam int COUNT_WIDTH     = 14;

  localparam logic [COUNT_WIDTH-1:0] COUNT_MIN      = 14'h0001;
  localparam logic [COUNT_WIDTH-1:0] COUNT_MAX      = 14'h3FFE;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ENDLESS  = 14'h3FFF;
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET    = 14'h0001;

  typedef enum logic [1:0] {
    TRIG_NONE     = 2'b00,
    TRIG_LEVEL    = 2'b01,
    TRIG_EDGE     = 2'b10,
    TRIG_SOFTWARE = 2'b11
  } trig_mode_type;

  typedef enum logic [1:0] {
    SYNC_NONE     = 2'b00,
    SYNC_INTERNAL = 2'b01,
    SYNC_EXTERNAL = 2'b10
  } sync_mode_type;

  typedef enum logic [1:0] {
    GATE_IDLE    = 2'b00,
    GATE_COUNT   = 2'b01,
    GATE_ENDLESS = 2'b10
  } gate_state_type;

  typedef struct packed {
    trig_mode_type              mode;
    logic                       levelHigh;
    logic                       edgeRising;
    logic [COUNT_WIDTH-1:0]     count;
    sync_mode_type              sync;
  } config_type;

  localparam config_type CONFIG_RESET = '{
    mode:       TRIG_NONE,
    levelHigh:  1'b1,
    edgeRising: 1'b1,
    count:      COUNT_RESET,
    sync:       SYNC_INTERNAL
  };

endpackage

// >>> src/trigger_conditioner.sv
// Purpose: brings the trigger pin into the clock domain, finds edges
// Assumes: trigger pin is asynchronous to clock
// Notes:   edge pulse lasts one enabled cycle
module trigger_conditioner
  import trigger_gate_pkg::*;
(
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic clockEnable,
  input  wire logic triggerPin,
  input  wire logic edgeRising,
  output logic      syncLevel,
  output logic      edgeEvent
);

  logic metaStage;
  logic prevLevel;
  wire  logic risingSeen  = syncLevel & ~prevLevel;
  wire  logic fallingSeen = ~syncLevel & prevLevel;
  wire  logic selectedSeen = edgeRising ? risingSeen : fallingSeen;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (srst) begin
      metaStage <= 1'b0;
      syncLevel <= 1'b0;
      prevLevel <= 1'b0;
      edgeEvent <= 1'b0;
    end else if (clockEnable) begin
      metaStage <= triggerPin; // RULE13
      syncLevel <= metaStage; // RULE13
      prevLevel <= syncLevel;
      edgeEvent <= selectedSeen; // RULE4
    end
  end

  chk_edge_one_pulse: assert property ( // RULE13
    @(posedge clock) disable iff (srst)
    clockEnable && edgeEvent |=> !edgeEvent || !clockEnable)
    else $error("edge event lasted more than one cycle");

  chk_edge_select: assert property ( // RULE4
    @(posedge clock) disable iff (srst)
    clockEnable && syncLevel && !prevLevel |=> edgeEvent == $past(edgeRising))
    else $error("rising edge event does not follow edge selection");

endmodule

// >>> src/measurement_trigger_gate.sv
// Purpose: decides when measured values pass to the output stream
// Assumes: inValid/inData and control come from logic on clock
// Notes:   trigger pin is synchronised inside trigger_conditioner
//
// Function
// RULE1: level mode passes values while trigger is at active level
// RULE2: level mode active level selectable high or low
// RULE3: edge event emits the preset count or starts endless output
// RULE4: edge mode selects rising or falling edge; only that one counts
// RULE5: software mode starts output on a software command
// RULE6: software event emits preset count or endless output like edge
// RULE7: software start timing is loose; no cycle-exact alignment needed
// RULE8: sync setting is none, internal or external and reads back
// RULE9: count setting accepts 1 to 16382 values per trigger event
// RULE10: count 16383 means endless output after a trigger event
// RULE11: stop command halts triggering and ends endless output; code only forces idle, later events restart it
// RULE12: level or edge triggering with external sync is rejected
// RULE13: trigger synchronised, one event per edge, reset clears to idle
// RULE14: no-trigger mode passes values continuously
module measurement_trigger_gate
  import trigger_gate_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic                   clockEnable,
  input  wire logic                   triggerPin,
  input  wire logic                   cfgWrite,
  input  wire config_type             cfgIn,
  input  wire logic                   softwareTrigger,
  input  wire logic                   stopRequest,
  input  wire logic                   inValid,
  input  wire logic [DATA_WIDTH-1:0]  inData,
  output config_type                  cfgActive,
  output logic                        cfgRejected,
  output logic                        gateOpen,
  output logic                        outValid,
  output logic [DATA_WIDTH-1:0]       outData
);

  function automatic logic configLegal(input config_type c);
    logic hwTrig;
    logic countOk;
    hwTrig  = (c.mode == TRIG_LEVEL) || (c.mode == TRIG_EDGE);
    countOk = (c.count >= COUNT_MIN);
    configLegal = countOk && (c.sync != 2'b11)
                  && !(hwTrig && c.sync == SYNC_EXTERNAL);
  endfunction

  gate_state_type         state;
  gate_state_type         next_state;
  logic [COUNT_WIDTH-1:0] remaining;
  logic [COUNT_WIDTH-1:0] next_remaining;
  logic                   syncLevel;
  logic                   edgeEvent;

  trigger_conditioner conditioner (
    .clock       (clock),
    .srst        (srst),
    .clockEnable (clockEnable),
    .triggerPin  (triggerPin),
    .edgeRising  (cfgActive.edgeRising),
    .syncLevel   (syncLevel),
    .edgeEvent   (edgeEvent)
  );

  wire logic writeLegal = cfgWrite && configLegal(cfgIn);
  wire logic levelMet   = (syncLevel == cfgActive.levelHigh); // RULE2
  wire logic edgeTrig   = (cfgActive.mode == TRIG_EDGE) && edgeEvent;
  // software command is taken on whatever cycle it lands, no alignment
  wire logic softTrig   = (cfgActive.mode == TRIG_SOFTWARE)
                          && softwareTrigger; // RULE5 RULE7
  wire logic trigEvent  = edgeTrig || softTrig;
  wire logic endless    = (cfgActive.count == COUNT_ENDLESS); // RULE10

  wire logic passNow =
      (cfgActive.mode == TRIG_NONE) || // RULE14
      ((cfgActive.mode == TRIG_LEVEL) && levelMet) || // RULE1
      (state != GATE_IDLE);
  wire logic consumed = inValid && passNow;

  always_comb begin
    next_state     = state;
    next_remaining = remaining;
    unique case (state)
      GATE_IDLE: begin
        next_state = GATE_IDLE;
      end
      GATE_COUNT: begin
        if (consumed) begin
          next_remaining = remaining - 14'h0001; // RULE9
          if (remaining == 14'h0001) begin
            next_state = GATE_IDLE; // RULE9
          end
        end
      end
      GATE_ENDLESS: begin
        next_state = GATE_ENDLESS; // RULE10
      end
      default: begin
        next_state = GATE_IDLE;
      end
    endcase
    // a new event restarts the count; stop and reconfiguration win
    if (trigEvent) begin
      next_state     = endless ? GATE_ENDLESS : GATE_COUNT; // RULE3 RULE6
      next_remaining = cfgActive.count; // RULE3 RULE6
    end
    if (stopRequest || cfgWrite) begin
      next_state     = GATE_IDLE; // RULE11
      next_remaining = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state     <= GATE_IDLE; // RULE13
      remaining <= '0; // RULE13
    end else if (clockEnable) begin
      state     <= next_state;
      remaining <= next_remaining;
    end
  end

  // an illegal write leaves the previous setting in force
  always_ff @(posedge clock) begin
    if (srst) begin
      cfgActive   <= CONFIG_RESET;
      cfgRejected <= 1'b0;
    end else if (clockEnable && cfgWrite) begin
      cfgRejected <= !writeLegal; // RULE12
      if (writeLegal) begin
        cfgActive <= cfgIn; // RULE8
      end
    end
  end

  // registered stage: adds one cycle of latency but keeps outputs clean
  always_ff @(posedge clock) begin
    if (srst) begin
      outValid <= 1'b0;
      outData  <= '0;
      gateOpen <= 1'b0;
    end else if (clockEnable) begin
      outValid <= consumed; // RULE1 RULE2 RULE14
      outData  <= inData;
      gateOpen <= passNow;
    end
  end

  sequence burstArmed;
    clockEnable && trigEvent && !stopRequest && !cfgWrite && !endless;
  endsequence

  sequence endlessArmed;
    clockEnable && trigEvent && !stopRequest && !cfgWrite && endless;
  endsequence

  chk_level_pass: assert property ( // RULE1
    @(posedge clock) disable iff (srst)
    clockEnable && cfgActive.mode == TRIG_LEVEL && inValid
      && syncLevel == cfgActive.levelHigh |=> outValid)
    else $error("level met but value not passed");

  chk_level_block: assert property ( // RULE2
    @(posedge clock) disable iff (srst)
    clockEnable && cfgActive.mode == TRIG_LEVEL && state == GATE_IDLE
      && syncLevel != cfgActive.levelHigh |=> !outValid)
    else $error("value passed while level inactive");

  chk_edge_start: assert property ( // RULE3
    @(posedge clock) disable iff (srst)
    burstArmed and (cfgActive.mode == TRIG_EDGE)
      |=> state == GATE_COUNT && remaining == $past(cfgActive.count))
    else $error("edge event did not load the count");

  chk_soft_start: assert property ( // RULE5
    @(posedge clock) disable iff (srst)
    burstArmed and (cfgActive.mode == TRIG_SOFTWARE) |=> state == GATE_COUNT)
    else $error("software command did not start output");

  chk_soft_count: assert property ( // RULE6
    @(posedge clock) disable iff (srst)
    burstArmed and (cfgActive.mode == TRIG_SOFTWARE)
      |=> remaining == $past(cfgActive.count))
    else $error("software command did not load the count");

  // reset acts whatever the clock enable does
  chk_reset_idle: assert property ( // RULE13
    @(posedge clock)
    srst |=> state == GATE_IDLE && !outValid && !gateOpen
      && cfgActive == CONFIG_RESET)
    else $error("reset did not return the gate to idle");

  chk_endless_hold: assert property ( // RULE10
    @(posedge clock) disable iff (srst)
    endlessArmed |=> state == GATE_ENDLESS ##1
      (state == GATE_ENDLESS || $past(stopRequest) || $past(cfgWrite)))
    else $error("endless output did not start or hold");

  chk_count_stop: assert property ( // RULE9
    @(posedge clock) disable iff (srst)
    clockEnable && state == GATE_COUNT && remaining == 14'h0001
      && inValid && !trigEvent |=> state == GATE_IDLE)
    else $error("burst did not end after the last value");

  chk_stop_idle: assert property ( // RULE11
    @(posedge clock) disable iff (srst)
    clockEnable && stopRequest |=> state == GATE_IDLE)
    else $error("stop did not return the gate to idle");

  chk_ext_reject: assert property ( // RULE12
    @(posedge clock) disable iff (srst)
    clockEnable && cfgWrite && cfgIn.sync == SYNC_EXTERNAL
      && (cfgIn.mode == TRIG_LEVEL || cfgIn.mode == TRIG_EDGE)
      |=> cfgRejected && cfgActive == $past(cfgActive))
    else $error("hardware trigger with external sync was accepted");

  chk_sync_readback: assert property ( // RULE8
    @(posedge clock) disable iff (srst)
    clockEnable && writeLegal |=> cfgActive.sync == $past(cfgIn.sync))
    else $error("sync setting not read back");

  chk_free_pass: assert property ( // RULE14
    @(posedge clock) disable iff (srst)
    clockEnable && cfgActive.mode == TRIG_NONE && inValid
      |=> outValid && outData == $past(inData))
    else $error("value dropped in no-trigger mode");

endmodule

// >>> bench/trigger_source.sv
// Purpose: far-side model, drives the trigger pin and software command
// Assumes: bench asks for levels and command pulses on clock
// Notes:   pin moves one cycle after the request, like a slow source
module trigger_source (
  input  wire logic clock,
  input  wire logic level,
  input  wire logic fire,
  output logic      triggerPin,
  output logic      softwareTrigger
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    triggerPin = 1'b0;
    softwareTrigger = 1'b0;
  end
  always @(posedge clock) begin
    triggerPin <= level;
    softwareTrigger <= fire;
  end
endmodule

// >>> bench/tb_measurement_trigger_gate.sv
// Purpose: self-checking bench of the measurement trigger gate
// Assumes: inValid high every cycle, so passed values equal open cycles
// Notes:   data words come from an lfsr seeded at 80
module tb_measurement_trigger_gate;
  timeunit 1ns;
  timeprecision 1ps;
  import trigger_gate_pkg::*;
  logic clock = 1'b0, srst = 1'b1, clockEnable = 1'b1, cfgWrite = 1'b0;
  logic stopRequest = 1'b0, inValid = 1'b1, level = 1'b0, fire = 1'b0;
  logic [DATA_WIDTH-1:0] inData = '0, lastIn = '0, outData;
  logic triggerPin, softwareTrigger, cfgRejected, gateOpen, outValid;
  config_type cfgIn = CONFIG_RESET, cfgActive, saved;
  logic [15:0] rnd = 16'h0050;
  int err_total = 0, total_checks = 0, nOut = 0;
  always #2 clock = ~clock;
  trigger_source src (.clock(clock), .level(level), .fire(fire),
    .triggerPin(triggerPin), .softwareTrigger(softwareTrigger));
  measurement_trigger_gate dut (.clock(clock), .srst(srst),
    .clockEnable(clockEnable), .triggerPin(triggerPin), .cfgWrite(cfgWrite),
    .cfgIn(cfgIn), .softwareTrigger(softwareTrigger),
    .stopRequest(stopRequest), .inValid(inValid), .inData(inData),
    .cfgActive(cfgActive), .cfgRejected(cfgRejected), .gateOpen(gateOpen),
    .outValid(outValid), .outData(outData));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_cfg(input config_type got, input config_type exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: config %h expected %h", $time, got, exp);
    end
  endtask
  // enable as the design saw it at the last rising edge
  logic enSeen = 1'b1;
  always @(posedge clock) begin
    rnd <= lfsr(rnd);
    inData <= {rnd, ~rnd};
    enSeen <= clockEnable;
  end
  // a passed word is the one presented during the cycle before
  // a frozen cycle repeats the old output, so it is not counted
  always @(negedge clock) begin
    if (outValid === 1'b1 && enSeen) begin
      nOut++;
      check_val(outData, lastIn);
    end
    lastIn <= inData;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic setup(input trig_mode_type m, input logic lh, input logic er,
                       input logic [COUNT_WIDTH-1:0] c, input sync_mode_type s);
    @(posedge clock);
    cfgIn <= '{mode: m, levelHigh: lh, edgeRising: er, count: c, sync: s};
    cfgWrite <= 1'b1;
    @(posedge clock);
    cfgWrite <= 1'b0;
    @(negedge clock);
  endtask
  task automatic pin(input logic v, input int n);
    @(posedge clock);
    level <= v;
    tick(n);
  endtask
  task automatic fire_cmd();
    @(posedge clock);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
  endtask
  // looks just after a falling edge, once the monitor has counted it
  task automatic expect_out(input int waitN, input int exp);
    repeat (waitN) @(negedge clock);
    #1;
    check_val(nOut, exp);
    nOut = 0;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(50000 * CLOCK_PERIOD_NS);
    err_total++;
    test_done();
  end
  initial begin
    int len;
    tick(4);
    srst <= 1'b0;
    @(negedge clock);
    check_cfg(cfgActive, CONFIG_RESET);
    nOut = 0;
    expect_out(10, 10);
    check_val(gateOpen, 1'b1);
    setup(TRIG_EDGE, 1'b1, 1'b1, 14'h0003, SYNC_NONE);
    check_cfg(cfgActive, cfgIn);
    saved = cfgActive;
    setup(TRIG_LEVEL, 1'b1, 1'b1, 14'h0003, SYNC_EXTERNAL);
    check_val(cfgRejected, 1'b1);
    check_cfg(cfgActive, saved);
    setup(TRIG_SOFTWARE, 1'b1, 1'b1, 14'h0000, SYNC_NONE);
    check_val(cfgRejected, 1'b1);
    setup(TRIG_NONE, 1'b1, 1'b1, COUNT_MIN, sync_mode_type'(2'h3));
    check_val(cfgRejected, 1'b1);
    setup(TRIG_EDGE, 1'b1, 1'b1, 14'h0003, SYNC_EXTERNAL);
    check_val(cfgRejected, 1'b1);
    check_cfg(cfgActive, saved);
    for (int p = 0; p < 2; p++) begin
      len = 4 + rnd[3:0];
      pin(p[0], 8);
      setup(TRIG_LEVEL, ~p[0], 1'b1, COUNT_MIN, SYNC_INTERNAL);
      check_val(cfgRejected, 1'b0);
      tick(6);
      nOut = 0;
      pin(~p[0], len - 1);
      pin(p[0], 0);
      expect_out(12, len);
    end
    setup(TRIG_EDGE, 1'b1, 1'b1, 14'h0003, SYNC_NONE);
    pin(1'b0, 12);
    pin(1'b1, 0);
    expect_out(24, 3);
    setup(TRIG_EDGE, 1'b1, 1'b0, 14'h0005, SYNC_INTERNAL);
    pin(1'b0, 6);
    // freeze in mid-burst: the count must survive the stall
    clockEnable <= 1'b0;
    tick(3);
    clockEnable <= 1'b1;
    expect_out(24, 5);
    setup(TRIG_SOFTWARE, 1'b1, 1'b1, 14'h0002, SYNC_NONE);
    pin(1'b1, 12);
    check_val(nOut, 0);
    fire_cmd();
    expect_out(30, 2);
    setup(TRIG_SOFTWARE, 1'b1, 1'b1, COUNT_MAX, SYNC_INTERNAL);
    fire_cmd();
    expect_out(16420, 16382);
    setup(TRIG_SOFTWARE, 1'b1, 1'b1, COUNT_ENDLESS, SYNC_NONE);
    fire_cmd();
    tick(20000);
    @(negedge clock);
    check_val(gateOpen, 1'b1);
    check_val(nOut > 19990, 1'b1);
    @(posedge clock);
    stopRequest <= 1'b1;
    tick(1);
    stopRequest <= 1'b0;
    tick(4);
    nOut = 0;
    expect_out(30, 0);
    check_val(gateOpen, 1'b0);
    // second reset in mid-run: setting and gate go back to their defaults
    @(posedge clock);
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    @(negedge clock);
    check_cfg(cfgActive, CONFIG_RESET);
    check_val(cfgRejected, 1'b0);
    nOut = 0;
    expect_out(8, 8);
    test_done();
  end
endmodule
